// File: src/bsp_pkg.sv
// Shared constants and types for the blit status and pipeline block
package bsp_pkg;

    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int DW          = 16;
    localparam int WORDS_W     = 17;
    localparam int RB_BUSY_BIT = 14;
    localparam int RB_NZ_BIT   = 13;
    localparam int SIZE_H_LSB  = 6;
    localparam int SIZE_H_W    = 10;
    localparam int SIZE_W_W    = 6;

    // Channel-use code bit positions in control word zero
    localparam int USE_A = 3;
    localparam int USE_B = 2;
    localparam int USE_C = 1;
    localparam int USE_D = 0;

    // ------------------------------------------------------------
    // Reset values and bus slot channel codes
    // ------------------------------------------------------------
    localparam logic [DW-1:0] RB_RESET = 16'h0000;
    localparam logic [1:0]    CH_A     = 2'h0;
    localparam logic [1:0]    CH_B     = 2'h1;
    localparam logic [1:0]    CH_C     = 2'h2;
    localparam logic [1:0]    CH_D     = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SRC   = 5'b00010,
        ST_TAIL  = 5'b00100,
        ST_FLUSH = 5'b01000,
        ST_LAST  = 5'b10000
    } bsp_state_t;

endpackage

// File: src/bsp_pipe_if.sv
// Carrier between the slot sequencer and the two-stage data pipeline
`timescale 1ns/1ps
interface bsp_pipe_if;
    import bsp_pkg::*;
    logic          clr;
    logic          push;
    logic          src_valid;
    logic [DW-1:0] a;
    logic [DW-1:0] b;
    logic [DW-1:0] c;
    logic [7:0]    lf;
    logic [DW-1:0] dest;
    logic          nonzero;
    logic          s1_valid;

    modport eng  (output clr, push, src_valid, a, b, c, lf, input dest, nonzero, s1_valid);
    modport pipe (input clr, push, src_valid, a, b, c, lf, output dest, nonzero, s1_valid);
endinterface

// File: src/bsp_pipe.sv
// Two-stage data pipeline: logic combination, then zero detect
`timescale 1ns/1ps
module bsp_pipe (
    input  wire logic   clk,
    input  wire logic   rst,
    bsp_pipe_if.pipe    pif
);
    import bsp_pkg::*;

    logic [DW-1:0] comb;
    logic [DW-1:0] s1_res_reg;
    logic          s1_valid_reg;
    logic [DW-1:0] s2_res_reg;
    logic          nz_reg;

    // ------------------------------------------------------------
    // Stage one: per-bit minterm select
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DW; gi++) begin : g_bit
            assign comb[gi] = pif.lf[{pif.a[gi], pif.b[gi], pif.c[gi]}];
        end
    endgenerate

    // A bubble push drains the last set into stage two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_res_reg   <= 16'h0000;
            s1_valid_reg <= 1'b0;
        end else if (pif.clr) begin
            s1_res_reg   <= 16'h0000;
            s1_valid_reg <= 1'b0;
        end else if (pif.push) begin
            s1_res_reg   <= comb;
            s1_valid_reg <= pif.src_valid;
        end
    end

    // ------------------------------------------------------------
    // Stage two: output word and zero tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s2_res_reg <= 16'h0000;
        end else if (pif.push) begin
            s2_res_reg <= s1_res_reg;
        end
    end

    // Evaluated whether or not the word is ever written out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nz_reg <= 1'b0;
        end else if (pif.clr) begin
            nz_reg <= 1'b0;
        end else if (pif.push && s1_valid_reg && (s1_res_reg != 16'h0000)) begin
            nz_reg <= 1'b1;
        end
    end

    assign pif.dest     = s2_res_reg;
    assign pif.nonzero  = nz_reg;
    assign pif.s1_valid = s1_valid_reg;

    AST_NZ_ANY_WORD: assert property (@(posedge clk) disable iff (rst)
        (pif.push && !pif.clr && s1_valid_reg && s1_res_reg != 16'h0000) |=> nz_reg)
        else $error("Nonzero word did not raise the nonzero tracker");

    AST_STAGE_HANDOFF: assert property (@(posedge clk) disable iff (rst)
        (pif.push && !pif.clr) |=> (s2_res_reg == $past(s1_res_reg)))
        else $error("Stage two did not take the stage one word");
endmodule

// File: src/bsp_engine.sv
// Blit engine status, completion signalling and bus slot sequencing
`timescale 1ns/1ps

// Contract
// - Writing the size register launches a blit, so all other setup must come first.
// - The engine never stalls the host; it only requests bus slots of its own.
// - Bit 14 of the readback word reads one while a blit is in progress.
// - In original mode busy rises only once the first memory slot is granted.
// - In later mode busy rises at once on the size register write.
// - Each finished blit sets a sticky completion flag, which interrupts when enabled.
// - The engine tracks whether every computed destination bit was zero, even without D.
// - The nonzero result reads at bit 13 of the readback word and is valid after completion.
// - Data passes two pipeline stages, combination then zero detect, one set per push.
// - Two source sets are fetched before the first destination word is written, except in a one-word blit, which fetches one.
// - The channel-use code sets the slot pattern, with writes lagging and a trailing write.
// - The slot order is typical only; slots wait on grants and shift with contention.
module bsp_engine (
    input  wire logic                   CLK_SYS,
    input  wire logic                   RST,
    input  wire logic                   BLIT_SIZE_WR,
    input  wire logic [bsp_pkg::DW-1:0] BLIT_SIZE_DATA,
    input  wire logic [3:0]             CTRL_WORD0_USE,
    input  wire logic [7:0]             CTRL_WORD0_LF,
    input  wire logic                   EARLY_BUSY,
    input  wire logic                   BUS_GRANT,
    input  wire logic [bsp_pkg::DW-1:0] SRC_RDATA,
    input  wire logic                   IRQ_ENABLE,
    input  wire logic                   IRQ_FLAG_CLR,
    output logic                        BUS_REQ,
    output logic                        SLOT_VALID,
    output logic [1:0]                  SLOT_CHAN,
    output logic                        SLOT_WRITE,
    output logic [bsp_pkg::DW-1:0]      SLOT_WDATA,
    output logic [bsp_pkg::DW-1:0]      DMA_CTRL_READBACK,
    output logic                        BLIT_DONE_FLAG,
    output logic                        BLIT_IRQ
);
    import bsp_pkg::*;

    bsp_pipe_if pif ();

    bsp_state_t         state_reg;
    bsp_state_t         state_next;
    logic [2:0]         rem_reg;
    logic [2:0]         rem_next;
    logic [WORDS_W-1:0] word_reg;
    logic [WORDS_W-1:0] word_next;
    logic [WORDS_W-1:0] total_reg;
    logic [3:0]         use_reg;
    logic [7:0]         lf_reg;
    logic [DW-1:0]      a_reg;
    logic [DW-1:0]      b_reg;
    logic [DW-1:0]      c_reg;
    logic               req_reg;
    logic               got_grant_reg;
    logic               flag_reg;
    logic               flag_next;
    logic               launch;
    logic               grant_ok;
    logic               last_word;
    logic               push;
    logic               src_valid;
    logic               done;
    logic               wr_issue;
    logic [1:0]         src_ch;
    logic [SIZE_H_W:0]  h_words;
    logic [SIZE_W_W:0]  w_words;
    logic [1:0]         push_cnt_reg;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Lowest pending source in A, B, C order
    function automatic logic [1:0] first_src(input logic [2:0] rem);
        if (rem[2]) begin
            return CH_A;
        end else if (rem[1]) begin
            return CH_B;
        end
        return CH_C;
    endfunction

    function automatic logic needs_slot(input bsp_state_t st, input logic [2:0] rem,
                                        input logic [WORDS_W-1:0] wd, input logic d_on);
        return ((st == ST_SRC) && (rem != 3'b000)) || ((st == ST_TAIL) && (wd != '0))
            || ((st == ST_LAST) && d_on);
    endfunction

    // Zero in a size field means the largest count
    assign h_words  = (BLIT_SIZE_DATA[DW-1:SIZE_H_LSB] == '0) ? 11'h400
                                                          : {1'b0, BLIT_SIZE_DATA[DW-1:SIZE_H_LSB]};
    assign w_words  = (BLIT_SIZE_DATA[SIZE_W_W-1:0] == '0) ? 7'h40
                                                         : {1'b0, BLIT_SIZE_DATA[SIZE_W_W-1:0]};
    assign launch    = BLIT_SIZE_WR && (state_reg == ST_IDLE);
    assign grant_ok  = req_reg && BUS_GRANT;
    assign last_word = (word_reg == total_reg - 17'h0_0001);
    assign src_ch    = first_src(rem_reg);

    // ------------------------------------------------------------
    // Slot sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        rem_next   = rem_reg;
        word_next  = word_reg;
        push       = 1'b0;
        src_valid  = 1'b1;
        done       = 1'b0;
        wr_issue   = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (launch) begin
                    state_next = ST_SRC;
                    rem_next   = CTRL_WORD0_USE[USE_A:USE_C];
                    word_next  = '0;
                end
            end
            ST_SRC: begin
                if (rem_reg == 3'b000) begin
                    push = 1'b1;
                    if (use_reg[USE_D]) begin
                        state_next = ST_TAIL;
                    end else if (last_word) begin
                        state_next = ST_FLUSH;
                    end else begin
                        word_next = word_reg + 17'h0_0001;
                        rem_next  = use_reg[USE_A:USE_C];
                    end
                end else if (grant_ok) begin
                    rem_next = rem_reg & ~(3'b100 >> src_ch);
                end
            end
            ST_TAIL: begin
                // Word zero leaves an idle slot: no destination is ready yet
                if (word_reg == '0 || grant_ok) begin
                    wr_issue = (word_reg != '0);
                    if (last_word) begin
                        state_next = ST_FLUSH;
                    end else begin
                        state_next = ST_SRC;
                        word_next  = word_reg + 17'h0_0001;
                        rem_next   = use_reg[USE_A:USE_C];
                    end
                end
            end
            ST_FLUSH: begin
                push       = 1'b1;
                src_valid  = 1'b0;
                state_next = ST_LAST;
            end
            ST_LAST: begin
                if (!use_reg[USE_D] || grant_ok) begin
                    wr_issue   = use_reg[USE_D];
                    done       = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            rem_reg   <= 3'b000;
            word_reg  <= '0;
            req_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            rem_reg   <= rem_next;
            word_reg  <= word_next;
            // A request only, the host side keeps running meanwhile
            req_reg   <= needs_slot(state_next, rem_next, word_next,
                                    launch ? CTRL_WORD0_USE[USE_D] : use_reg[USE_D]);
        end
    end

    // Setup is captured at launch, so later host writes cannot disturb a blit
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            use_reg   <= 4'h0;
            lf_reg    <= 8'h00;
            total_reg <= '0;
        end else if (launch) begin
            use_reg   <= CTRL_WORD0_USE;
            lf_reg    <= CTRL_WORD0_LF;
            total_reg <= WORDS_W'(h_words) * WORDS_W'(w_words);
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            a_reg <= 16'h0000;
            b_reg <= 16'h0000;
            c_reg <= 16'h0000;
        end else if (state_reg == ST_SRC && rem_reg != 3'b000 && grant_ok) begin
            if (src_ch == CH_A) begin
                a_reg <= SRC_RDATA;
            end
            if (src_ch == CH_B) begin
                b_reg <= SRC_RDATA;
            end
            if (src_ch == CH_C) begin
                c_reg <= SRC_RDATA;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus slot outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SLOT_VALID <= 1'b0;
            SLOT_CHAN  <= CH_A;
            SLOT_WRITE <= 1'b0;
            SLOT_WDATA <= 16'h0000;
        end else begin
            SLOT_VALID <= (state_reg == ST_SRC && rem_reg != 3'b000 && grant_ok) || wr_issue;
            SLOT_CHAN  <= wr_issue ? CH_D : src_ch;
            SLOT_WRITE <= wr_issue;
            SLOT_WDATA <= pif.dest;
        end
    end

    assign BUS_REQ = req_reg;

    // ------------------------------------------------------------
    // Status, completion flag and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            got_grant_reg <= 1'b0;
        end else if (launch || done) begin
            // Cleared on finish too, so a later blit never inherits the last grant
            got_grant_reg <= 1'b0;
        end else if (grant_ok) begin
            got_grant_reg <= 1'b1;
        end
    end

    // Set beats clear so a finish is never lost
    assign flag_next = done | (flag_reg & ~IRQ_FLAG_CLR);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            flag_reg          <= 1'b0;
            BLIT_IRQ          <= 1'b0;
            DMA_CTRL_READBACK <= RB_RESET;
        end else begin
            flag_reg <= flag_next;
            BLIT_IRQ <= flag_next & IRQ_ENABLE;
            DMA_CTRL_READBACK <= RB_RESET;
            // Busy derives from next state, so it drops in the finishing cycle
            DMA_CTRL_READBACK[RB_BUSY_BIT] <= (state_next != ST_IDLE)
                && (EARLY_BUSY || got_grant_reg || grant_ok);
            DMA_CTRL_READBACK[RB_NZ_BIT] <= pif.nonzero;
        end
    end

    assign BLIT_DONE_FLAG = flag_reg;

    // ------------------------------------------------------------
    // Pipeline
    // ------------------------------------------------------------
    assign pif.clr       = launch;
    assign pif.push      = push;
    assign pif.src_valid = src_valid;
    assign pif.a         = a_reg;
    assign pif.b         = b_reg;
    assign pif.c         = c_reg;
    assign pif.lf        = lf_reg;

    bsp_pipe u_pipe (
        .clk (CLK_SYS),
        .rst (RST),
        .pif (pif)
    );

    // Valid pushes since launch, saturating at two
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            push_cnt_reg <= 2'h0;
        end else if (launch) begin
            push_cnt_reg <= 2'h0;
        end else if (push && src_valid && push_cnt_reg != 2'h2) begin
            push_cnt_reg <= push_cnt_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_launch;
        (state_reg == ST_IDLE) && BLIT_SIZE_WR;
    endsequence

    sequence s_finish;
        done ##1 1'b1;
    endsequence

    AST_LAUNCH_RUNS: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_launch |=> (state_reg == ST_SRC))
        else $error("Size write did not start a blit");
    AST_EARLY_BUSY: assert property (@(posedge CLK_SYS) disable iff (RST)
        (s_launch and EARLY_BUSY) |=> DMA_CTRL_READBACK[RB_BUSY_BIT])
        else $error("Busy not raised on size write");
    AST_LATE_BUSY: assert property (@(posedge CLK_SYS) disable iff (RST)
        (s_launch and !EARLY_BUSY) |=> !DMA_CTRL_READBACK[RB_BUSY_BIT])
        else $error("Busy raised before any granted slot");
    AST_BUSY_WHILE_RUN: assert property (@(posedge CLK_SYS) disable iff (RST)
        (EARLY_BUSY && state_reg != ST_IDLE && $past(state_reg != ST_IDLE))
        |-> DMA_CTRL_READBACK[RB_BUSY_BIT])
        else $error("Busy low during a blit");
    AST_DONE_TOGETHER: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_finish |-> (!DMA_CTRL_READBACK[RB_BUSY_BIT] && BLIT_DONE_FLAG))
        else $error("Busy clear and done flag not in the same cycle");
    AST_SET_WINS: assert property (@(posedge CLK_SYS) disable iff (RST)
        (done && IRQ_FLAG_CLR) |=> (BLIT_DONE_FLAG && (BLIT_IRQ == $past(IRQ_ENABLE))))
        else $error("Completion flag lost against a clear");
    AST_NZ_RESTART: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_launch |=> !pif.nonzero)
        else $error("Zero tracker not cleared on launch");
    AST_TWO_SETS_FIRST: assert property (@(posedge CLK_SYS) disable iff (RST)
        // A one-word blit has only one source set before its single write
        wr_issue |-> (push_cnt_reg == 2'h2 || total_reg == WORDS_W'(1)))
        else $error("Destination written before two source sets");
    AST_SLOT_ENABLED: assert property (@(posedge CLK_SYS) disable iff (RST)
        (SLOT_VALID && !SLOT_WRITE) |-> use_reg[USE_A - SLOT_CHAN])
        else $error("Fetch slot on a disabled channel");
    AST_NZ_READ: assert property (@(posedge CLK_SYS) disable iff (RST)
        (state_reg == ST_IDLE)[*2] |-> (DMA_CTRL_READBACK[RB_NZ_BIT] == pif.nonzero))
        else $error("Readback nonzero bit disagrees with tracker");
endmodule

// File: verif/bsp_bus_model.sv
// Bus arbiter and chip memory model facing the engine's slot interface
`timescale 1ns/1ps
module bsp_bus_model (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   bus_req,
    input  wire logic                   stall,
    input  wire logic [bsp_pkg::DW-1:0] fetch_data,
    output logic                        bus_grant,
    output logic [bsp_pkg::DW-1:0]      src_rdata
);
    import bsp_pkg::*;
    logic [1:0]    phase_reg;
    logic [DW-1:0] last_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
        end
    end

    // Competing traffic takes two slots of every three while stalling
    assign bus_grant = bus_req && (!stall || phase_reg == 2'h2);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_reg <= 16'h0000;
        end else begin
            last_reg <= src_rdata;
        end
    end

    // Undriven bus inverts its last value each cycle, so stale data matches fetch_data every other cycle
    assign src_rdata = bus_grant ? fetch_data : ~last_reg;
endmodule

// File: verif/tb_blit_status_and_pipeline.sv
// Self-checking bench for the blit engine status and slot sequencing
`timescale 1ns/1ps
module tb_blit_status_and_pipeline;
    import bsp_pkg::*;
    localparam logic [DW-1:0] FETCH = 16'hA5C3;
    typedef struct packed {
        logic [3:0] use_c; logic [7:0] lf; logic [15:0] size;
        logic early; logic stall; logic ien; logic exp_nz;
    } bsp_row_t;
    logic          clk_sys = 1'b0, rst = 1'b1, size_wr = 1'b0, early_busy = 1'b1;
    logic          stall = 1'b0, irq_en = 1'b0, flag_clr = 1'b0;
    logic [DW-1:0] size_data = 16'h0000, src_rdata, slot_wdata, readback;
    logic [3:0]    use_code = 4'h0;
    logic [7:0]    lf = 8'h00;
    logic          bus_req, bus_grant, slot_valid, slot_write, done_flag, blit_irq;
    logic [1:0]    slot_chan;
    int            n_fail = 0, checks = 0, rd_cnt, wr_cnt, cur_words, cur_nsrc, cyc = 0;
    logic          granted = 1'b0;
    bsp_row_t      rows [16];

    bsp_engine dut_u (.CLK_SYS(clk_sys), .RST(rst), .BLIT_SIZE_WR(size_wr),
        .BLIT_SIZE_DATA(size_data), .CTRL_WORD0_USE(use_code), .CTRL_WORD0_LF(lf),
        .EARLY_BUSY(early_busy), .BUS_GRANT(bus_grant), .SRC_RDATA(src_rdata),
        .IRQ_ENABLE(irq_en), .IRQ_FLAG_CLR(flag_clr), .BUS_REQ(bus_req),
        .SLOT_VALID(slot_valid), .SLOT_CHAN(slot_chan), .SLOT_WRITE(slot_write),
        .SLOT_WDATA(slot_wdata), .DMA_CTRL_READBACK(readback),
        .BLIT_DONE_FLAG(done_flag), .BLIT_IRQ(blit_irq));
    bsp_bus_model bus_u (.clk(clk_sys), .rst(rst), .bus_req(bus_req), .stall(stall),
        .fetch_data(FETCH), .bus_grant(bus_grant), .src_rdata(src_rdata));

    always #50 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] seen);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Every source ever fetched holds FETCH, so each bit indexes LF at 7 or 0
    function automatic logic [DW-1:0] wexp(input logic [7:0] f);
        return (FETCH & {DW{f[7]}}) | (~FETCH & {DW{f[0]}});
    endfunction

    // Sampled mid-cycle, where the registered outputs have settled
    always @(negedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            give_verdict();
        end
        if (bus_req && bus_grant) granted = 1'b1;
        if (slot_valid && !slot_write) begin
            check("src_chan_enabled", 16'h0001, {15'h0, use_code[3 - slot_chan]});
            rd_cnt++;
        end
        if (slot_valid && slot_write) begin
            check("write_chan", {14'h0, CH_D}, {14'h0, slot_chan});
            check("slot_wdata", wexp(lf), slot_wdata);
            if (wr_cnt == 0 && cur_words > 1)
                check("two_sets_first", 16'h0001, {15'h0, rd_cnt >= 2 * cur_nsrc});
            wr_cnt++;
        end
    end

    // ------------------------------------------------------------
    // One blit from launch to completion, optionally rewriting size mid-run
    // ------------------------------------------------------------
    task automatic run(input bsp_row_t r, input logic poke);
        int n;
        logic prev;
        cur_words = (r.size[15:6] == 0 ? 1024 : r.size[15:6])
            * (r.size[5:0] == 0 ? 64 : r.size[5:0]);
        cur_nsrc = r.use_c[3] + r.use_c[2] + r.use_c[1];
        rd_cnt = 0;
        wr_cnt = 0;
        granted = 1'b0;
        use_code = r.use_c;
        lf = r.lf;
        early_busy = r.early;
        stall = r.stall;
        irq_en = r.ien;
        size_data = r.size;
        size_wr = 1'b1;
        flag_clr = 1'b1;
        @(negedge clk_sys);
        size_wr = 1'b0;
        flag_clr = 1'b0;
        if (r.early) check("busy_at_once", 16'h0001, {15'h0, readback[RB_BUSY_BIT]});
        prev = readback[RB_BUSY_BIT];
        n = 0;
        while (done_flag !== 1'b1 && n < 6000) begin
            if (!r.early && !granted)
                check("busy_before_grant", 16'h0000, {15'h0, readback[RB_BUSY_BIT]});
            // Host rule broken on purpose: the rewrite must be ignored
            size_wr = poke && readback[RB_BUSY_BIT] === 1'b1;
            size_data = poke ? 16'h0041 : r.size;
            // A clear held through the finish must lose against the set
            flag_clr = poke;
            prev = readback[RB_BUSY_BIT];
            @(negedge clk_sys);
            n++;
        end
        size_wr = 1'b0;
        flag_clr = 1'b0;
        check("busy_drop_with_flag", 16'h0002, {14'h0, prev, readback[RB_BUSY_BIT]});
        check("done_flag", 16'h0001, {15'h0, done_flag});
        check("nonzero_bit", {15'h0, r.exp_nz}, {15'h0, readback[RB_NZ_BIT]});
        check("spare_bits", 16'h0000, readback & 16'h9FFF);
        // Counts wait one cycle so the monitor has seen the final write slot
        @(negedge clk_sys);
        check("src_reads", cur_nsrc * cur_words, rd_cnt);
        check("d_writes", r.use_c[0] ? cur_words : 0, wr_cnt);
        check("irq_line", {15'h0, r.ien}, {15'h0, blit_irq});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{
            '{4'hF, 8'hCA, 16'h0043, 1, 0, 1, 1}, '{4'hE, 8'h00, 16'h0042, 0, 1, 0, 0},
            '{4'hD, 8'h80, 16'h0081, 1, 1, 1, 1}, '{4'hC, 8'h01, 16'h0042, 0, 0, 0, 1},
            '{4'hB, 8'h7E, 16'h0043, 1, 0, 0, 0}, '{4'hA, 8'hFF, 16'h0041, 0, 1, 1, 1},
            '{4'h9, 8'hF0, 16'h0043, 1, 1, 0, 1}, '{4'h8, 8'h0F, 16'h0042, 0, 0, 1, 1},
            '{4'h7, 8'h3C, 16'h0082, 1, 0, 1, 0}, '{4'h6, 8'hC3, 16'h0041, 0, 1, 0, 1},
            '{4'h5, 8'hAA, 16'h0043, 1, 1, 1, 1}, '{4'h4, 8'h55, 16'h0042, 0, 0, 0, 1},
            '{4'h3, 8'h66, 16'h0081, 1, 0, 0, 0}, '{4'h2, 8'h99, 16'h0043, 0, 1, 1, 1},
            '{4'h1, 8'h81, 16'h0042, 1, 1, 0, 1}, '{4'h0, 8'h00, 16'h0041, 1, 0, 1, 0}};
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        check("readback_reset", RB_RESET, readback);
        // Zero results that follow nonzero ones also show the tracker restarting
        foreach (rows[i]) run(rows[i], 1'b0);
        // Size rewrite while running, with slow grants
        run('{4'hD, 8'hCA, 16'h0082, 1, 1, 1, 1}, 1'b1);
        // Flag clear drops flag and the interrupt line on the same edge
        flag_clr = 1'b1;
        @(negedge clk_sys);
        flag_clr = 1'b0;
        check("flag_cleared", 16'h0000, {15'h0, done_flag});
        @(negedge clk_sys);
        check("irq_cleared", 16'h0000, {15'h0, blit_irq});
        // Reset in mid-blit returns every output to idle
        use_code = 4'hF;
        size_data = 16'h0083;
        size_wr = 1'b1;
        @(negedge clk_sys);
        size_wr = 1'b0;
        repeat (5) @(negedge clk_sys);
        rst = 1'b1;
        @(negedge clk_sys);
        check("rst_readback", RB_RESET, readback);
        check("rst_outputs", 16'h0000, {11'h0, bus_req, slot_valid, slot_write, done_flag, blit_irq});
        rst = 1'b0;
        @(negedge clk_sys);
        run(rows[0], 1'b0);
        give_verdict();
    end
endmodule
